// [rtl/nfb_bank.sv]
/*
 Notch filter bank: five numbered notches, one custom notch and its two
 compensation stages, run one stage per clock over each sample.
 Assumes samples and settings arrive from logic on clk_sys.
*/
`timescale 1ns/1ns
// Contract
// - Six independent notches, all usable together.
// - Numbered notch frequency 10 to 5000 Hz.
// - Frequency 5000 bypasses that notch.
// - Numbered notch width code 0 to 20.
// - Numbered notch depth code 0 to 99.
// - Adaptive function overwrites notches three, four.
// - Coefficient 0 to 1000; 100 or less off.
// - Compensation frequencies 0 to 10000; zero off.
// - Custom frequency 10 to 5000; 5000 disables.
// - Custom width and depth coded like others.
// - Greatest attenuation at the notch frequency.
// - Depth sets centre ratio: 0 cut, 100 pass.
// - Depth ratio is code divided by hundred.
// - Width ratio 0.25 to 8, doubling per four.
// - Width is -3 dB bandwidth relative to frequency.
module nfb_bank
    import nfb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    input wire logic [NFB_SMP_W-1:0] inSample,
    input wire logic inVld,
    output logic inRdy,
    output logic [NFB_SMP_W-1:0] outSample,
    output logic outVld,
    input wire logic outRdy,
    input wire logic adaptEn,
    input wire nfb_notch_t adapt3,
    input wire nfb_notch_t adapt4
);
    typedef struct packed {
        nfb_cfg_t cfg;
        nfb_cfg_t sh;
        nfb_run_t st;
        logic [2:0] stg;
        logic [7:0][31:0] lp;
        logic [7:0][31:0] bp;
        logic [31:0] acc;
        logic outVld;
        logic [15:0] outData;
        logic [15:0] rdata;
    } nfb_st_t;
    nfb_st_t s;
    nfb_st_t next_s;

    logic [NFB_SMP_W-1:0] fifoData;
    logic fifoVld;
    logic pop;
    logic [7:0][21:0] coefF;
    logic [7:0][11:0] coefQ;
    logic [7:0][9:0] coefV;
    logic [7:0] stEn;

    // Queue decouples the source from the eight-cycle engine
    nfb_fifo #(.W(NFB_SMP_W), .D(NFB_FIFO_D)) u_fifo (
        .clk_sys(clk_sys),
        .srst(srst),
        .inData(inSample),
        .inVld(inVld),
        .inRdy(inRdy),
        .outData(fifoData),
        .outVld(fifoVld),
        .outRdy(pop)
    );

    // Stage coefficients come from the snapshot only, never from live settings
    for (genvar k = 0; k < NFB_STAGES; k++) begin : g_coef
        localparam int C = (k < NFB_CUSTOM) ? k : NFB_CUSTOM;
        logic [4:0] w;
        logic [13:0] wq;
        assign w = s.sh.n[C].width;
        assign wq = {5'h00, NFB_WBASE[w[1:0]]} << w[4:2];
        assign coefQ[k] = wq[13:2];
        if (k <= NFB_CUSTOM) begin : g_notch
            assign coefF[k] = 22'(s.sh.n[k].freq * NFB_FSCALE);
            assign coefV[k] = {3'h0, s.sh.n[k].depth};
            assign stEn[k] = s.sh.n[k].freq != NFB_FREQ_OFF[12:0];
        end else begin : g_comp
            // Compensation peaks ride on the custom notch width
            logic [13:0] cf;
            assign cf = (k == NFB_CUSTOM + 1) ? s.sh.cf1 : s.sh.cf2;
            assign coefF[k] = 22'(cf * NFB_FSCALE_DHZ);
            assign coefV[k] = s.sh.coef;
            assign stEn[k] = stEn[NFB_CUSTOM] && ({6'h00, s.sh.coef} > NFB_COEF_ON)
                             && (cf != 14'h0000);
        end
    end

    assign pop = (s.st == NFB_IDLE) && !s.outVld && fifoVld;
    assign regRdata = s.rdata;
    assign outSample = s.outData;
    assign outVld = s.outVld;

    function automatic logic signed [63:0] sx(input logic [31:0] v);
        return {{32{v[31]}}, v};
    endfunction : sx

    always_comb begin
        logic signed [63:0] x, lp, bp, f, q, g, lpN, hpN, bpN, y;
        next_s = s;
        x = sx(s.acc);
        lp = sx(s.lp[s.stg]);
        bp = sx(s.bp[s.stg]);
        f = $signed({42'h0, coefF[s.stg]});
        q = $signed({52'h0, coefQ[s.stg]});
        g = 64'sd100 - $signed({54'h0, coefV[s.stg]});
        lpN = lp + ((f * bp) >>> NFB_FRAC);
        hpN = x - lpN - ((q * bp) >>> NFB_QFRAC);
        bpN = bp + ((f * hpN) >>> NFB_FRAC);
        // Notch output x - (1 - ratio) * band; at the centre band equals x
        y = x - (((((q * bpN) >>> NFB_QFRAC) * g) * NFB_PCT_MUL) >>> NFB_PCT_SH);

        // Register writes; out-of-range values are dropped, old value kept
        for (int i = 0; i < 6; i++) begin
            if (regWr && regAddr == NFB_NOTCH_BASE[i]) begin
                if (regWdata >= NFB_FREQ_MIN && regWdata <= NFB_FREQ_OFF) begin
                    next_s.cfg.n[i].freq = regWdata[12:0];
                end
            end else if (regWr && regAddr == NFB_NOTCH_BASE[i] + NFB_OFS_WIDTH) begin
                if (regWdata <= NFB_WIDTH_MAX) begin
                    next_s.cfg.n[i].width = regWdata[4:0];
                end
            end else if (regWr && regAddr == NFB_NOTCH_BASE[i] + NFB_OFS_DEPTH) begin
                if (regWdata <= NFB_DEPTH_MAX) begin
                    next_s.cfg.n[i].depth = regWdata[6:0];
                end
            end
        end
        if (regWr && regAddr == NFB_ADDR_COEF) begin
            if (regWdata <= NFB_COEF_MAX) begin
                next_s.cfg.coef = regWdata[9:0];
            end
        end else if (regWr && regAddr == NFB_ADDR_CF1) begin
            if (regWdata <= NFB_CF_MAX) begin
                next_s.cfg.cf1 = regWdata[13:0];
            end
        end else if (regWr && regAddr == NFB_ADDR_CF2) begin
            if (regWdata <= NFB_CF_MAX) begin
                next_s.cfg.cf2 = regWdata[13:0];
            end
        end
        // Adaptive values win over any software write in the same cycle
        if (adaptEn) begin
            next_s.cfg.n[2] = adapt3;
            next_s.cfg.n[3] = adapt4;
        end

        next_s.rdata = '0;
        if (regRd) begin
            for (int i = 0; i < 6; i++) begin
                if (regAddr == NFB_NOTCH_BASE[i]) begin
                    next_s.rdata = {3'h0, s.cfg.n[i].freq};
                end else if (regAddr == NFB_NOTCH_BASE[i] + NFB_OFS_WIDTH) begin
                    next_s.rdata = {11'h000, s.cfg.n[i].width};
                end else if (regAddr == NFB_NOTCH_BASE[i] + NFB_OFS_DEPTH) begin
                    next_s.rdata = {9'h000, s.cfg.n[i].depth};
                end
            end
            if (regAddr == NFB_ADDR_COEF) begin
                next_s.rdata = {6'h00, s.cfg.coef};
            end else if (regAddr == NFB_ADDR_CF1) begin
                next_s.rdata = {2'h0, s.cfg.cf1};
            end else if (regAddr == NFB_ADDR_CF2) begin
                next_s.rdata = {2'h0, s.cfg.cf2};
            end else if (regAddr == NFB_ADDR_STAT) begin
                next_s.rdata = {6'h00, s.st == NFB_RUN, adaptEn, stEn};
            end
        end

        if (s.outVld && outRdy) begin
            next_s.outVld = 1'b0;
        end
        case (s.st)
            NFB_IDLE: begin
                if (pop) begin
                    next_s.acc = {{8{fifoData[15]}}, fifoData, 8'h00};
                    next_s.sh = s.cfg;
                    next_s.stg = 3'h0;
                    next_s.st = NFB_RUN;
                end
            end
            NFB_RUN: begin
                if (stEn[s.stg]) begin
                    next_s.lp[s.stg] = lpN[31:0];
                    next_s.bp[s.stg] = bpN[31:0];
                    next_s.acc = y[31:0];
                end else begin
                    // A bypassed stage passes the sample and forgets its history
                    next_s.lp[s.stg] = '0;
                    next_s.bp[s.stg] = '0;
                end
                next_s.stg = s.stg + 3'h1;
                if (s.stg == 3'(NFB_STAGES - 1)) begin
                    next_s.st = NFB_IDLE;
                    next_s.outVld = 1'b1;
                    if ($signed(next_s.acc[31:8]) > 24'sh007fff) begin
                        next_s.outData = 16'h7fff;
                    end else if ($signed(next_s.acc[31:8]) < -24'sh008000) begin
                        next_s.outData = 16'h8000;
                    end else begin
                        next_s.outData = next_s.acc[23:8];
                    end
                end
            end
            default: begin
                next_s.st = NFB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s <= '0;
            s.cfg <= NFB_CFG_RST;
            s.sh <= NFB_CFG_RST;
        end else begin
            s <= next_s;
        end
    end

    // Checks
    logic fOk, wOk, dOk;
    always_comb begin
        fOk = 1'b1;
        wOk = 1'b1;
        dOk = 1'b1;
        for (int i = 0; i < 6; i++) begin
            fOk = fOk && {3'h0, s.cfg.n[i].freq} >= NFB_FREQ_MIN
                  && {3'h0, s.cfg.n[i].freq} <= NFB_FREQ_OFF;
            wOk = wOk && {11'h000, s.cfg.n[i].width} <= NFB_WIDTH_MAX;
            dOk = dOk && {9'h000, s.cfg.n[i].depth} <= NFB_DEPTH_MAX;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    property p_freq_rng;
        fOk;
    endproperty
    a_freq_rng: assert property (p_freq_rng) else $error("notch frequency out of range");
    property p_width_rng;
        regWr |=> wOk;
    endproperty
    a_width_rng: assert property (p_width_rng) else $error("width code out of range");
    property p_depth_rng;
        regWr |=> dOk;
    endproperty
    a_depth_rng: assert property (p_depth_rng) else $error("depth code out of range");
    property p_adapt;
        adaptEn |=> s.cfg.n[2] == $past(adapt3) && s.cfg.n[3] == $past(adapt4);
    endproperty
    a_adapt: assert property (p_adapt) else $error("adaptive values not taken");
    property p_comp_rng;
        regWr |=> {6'h00, s.cfg.coef} <= NFB_COEF_MAX && {2'h0, s.cfg.cf1} <= NFB_CF_MAX
                  && {2'h0, s.cfg.cf2} <= NFB_CF_MAX;
    endproperty
    a_comp_rng: assert property (p_comp_rng) else $error("compensation setting out of range");
    property p_comp_off;
        {6'h00, s.sh.coef} <= NFB_COEF_ON |-> !stEn[6] && !stEn[7];
    endproperty
    a_comp_off: assert property (p_comp_off) else $error("compensation active while off");
    property p_bypass;
        s.st == NFB_RUN && !stEn[s.stg] |=> s.acc == $past(s.acc);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypassed stage altered sample");
    property p_one_out;
        pop |-> ##9 s.outVld;
    endproperty
    a_one_out: assert property (p_one_out) else $error("no output nine cycles after input");
    property p_snap;
        s.st == NFB_RUN |=> $stable(s.sh) || $past(s.stg) == 3'h7;
    endproperty
    a_snap: assert property (p_snap) else $error("coefficients changed mid-sample");
    // Ratio doubles every four codes; spot-check each doubling point
    property p_width_map;
        (s.sh.n[0].width == 5'h00 |-> coefQ[0] == 12'h040)
        and (s.sh.n[0].width == 5'h04 |-> coefQ[0] == 12'h080)
        and (s.sh.n[0].width == 5'h08 |-> coefQ[0] == 12'h100)
        and (s.sh.n[0].width == 5'h0c |-> coefQ[0] == 12'h200)
        and (s.sh.n[0].width == 5'h10 |-> coefQ[0] == 12'h400)
        and (s.sh.n[0].width == 5'h14 |-> coefQ[0] == 12'h800);
    endproperty
    a_width_map: assert property (p_width_map) else $error("width code not on its ratio");

    // Output side: a taken sample leaves once and is held while stalled
    property p_out_hold;
        outVld && !outRdy |=> outVld && $stable(outSample);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output moved while stalled");
    property p_out_drop;
        outVld && outRdy |=> !outVld;
    endproperty
    a_out_drop: assert property (p_out_drop) else $error("output handed on twice");
    // Snapshot is the live set as it stood when the sample was taken
    property p_snap_pop;
        pop |=> s.sh == $past(s.cfg) && s.st == NFB_RUN && s.stg == 3'h0;
    endproperty
    a_snap_pop: assert property (p_snap_pop) else $error("snapshot missed");
    // A stage left out must not carry old history into its next use
    property p_history;
        s.st == NFB_RUN && !stEn[s.stg] |=> s.lp[s.stg - 3'h1] == 32'h0
                                            && s.bp[s.stg - 3'h1] == 32'h0;
    endproperty
    a_history: assert property (p_history) else $error("bypassed stage kept history");
    property p_custom_gate;
        !stEn[NFB_CUSTOM] |-> stEn[7:6] == 2'b00;
    endproperty
    a_custom_gate: assert property (p_custom_gate) else $error("compensation left on");
    // Read data stands one cycle only, so a stale value never looks fresh
    property p_rd_zero;
        !regRd |=> regRdata == 16'h0000;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read data outside its cycle");
    property p_stat_adapt;
        regRd && regAddr == NFB_ADDR_STAT |=> regRdata[8] == $past(adaptEn);
    endproperty
    a_stat_adapt: assert property (p_stat_adapt) else $error("status adaptive bit wrong");

    // Main scenarios: full queue, a sample through, all stages, adaptive clash
    c_full: cover property (!inRdy);
    c_sample: cover property (pop ##9 s.outVld && outRdy);
    c_all_on: cover property (s.st == NFB_RUN && stEn == 8'hff);
    c_adapt_wr: cover property (adaptEn && regWr && regAddr == NFB_NOTCH_BASE[2]);
    c_comp_on: cover property (s.st == NFB_RUN && stEn[7:6] == 2'b11);
endmodule : nfb_bank

// [rtl/nfb_pkg.sv]
/*
 Constants and types of the notch filter bank: register offsets,
 value ranges, reset values, width lookup and the carrier structs.
 Assumes a 16-bit register port and a fixed sample rate.
*/
package nfb_pkg;
    // Register offsets: each notch holds frequency, width, depth at base, +1, +2
    localparam logic [7:0] NFB_NOTCH_BASE [6] = '{8'h01, 8'h04, 8'h07, 8'h0a, 8'h18, 8'h2a};
    localparam logic [7:0] NFB_ADDR_COEF = 8'h27;
    localparam logic [7:0] NFB_ADDR_CF1 = 8'h28;
    localparam logic [7:0] NFB_ADDR_CF2 = 8'h29;
    localparam logic [7:0] NFB_ADDR_STAT = 8'h30;
    localparam logic [7:0] NFB_OFS_WIDTH = 8'h01;
    localparam logic [7:0] NFB_OFS_DEPTH = 8'h02;
    localparam int NFB_CUSTOM = 5;
    localparam int NFB_STAGES = 8;
    // Value ranges
    localparam logic [15:0] NFB_FREQ_MIN = 16'h000a;
    localparam logic [15:0] NFB_FREQ_OFF = 16'h1388;
    localparam logic [15:0] NFB_WIDTH_MAX = 16'h0014;
    localparam logic [15:0] NFB_DEPTH_MAX = 16'h0063;
    localparam logic [15:0] NFB_COEF_MAX = 16'h03e8;
    localparam logic [15:0] NFB_COEF_ON = 16'h0064;
    localparam logic [15:0] NFB_CF_MAX = 16'h2710;
    // Width ratios 1.00, 1.19, 1.41, 1.68 in Q8; each further 4 codes doubles
    localparam logic [8:0] NFB_WBASE [4] = '{9'h100, 9'h130, 9'h16a, 9'h1af};
    localparam int NFB_SAMPLE_HZ = 40000;
    localparam int NFB_FSCALE = int'(6.283185307 * 1048576.0 / NFB_SAMPLE_HZ);
    localparam int NFB_FSCALE_DHZ = int'(6.283185307 * 104857.6 / NFB_SAMPLE_HZ);
    localparam int NFB_FRAC = 20;
    localparam int NFB_QFRAC = 8;
    localparam int NFB_PCT_MUL = 655;
    localparam int NFB_PCT_SH = 16;
    localparam int NFB_SMP_W = 16;
    localparam int NFB_FIFO_D = 16;

    typedef struct packed {
        logic [12:0] freq;
        logic [4:0] width;
        logic [6:0] depth;
    } nfb_notch_t;

    typedef struct packed {
        nfb_notch_t [5:0] n;
        logic [9:0] coef;
        logic [13:0] cf1;
        logic [13:0] cf2;
    } nfb_cfg_t;

    localparam nfb_notch_t NFB_NOTCH_RST = '{freq: 13'h1388, width: 5'h02, depth: 7'h00};
    localparam nfb_cfg_t NFB_CFG_RST = '{n: {6{NFB_NOTCH_RST}}, coef: 10'h000,
                                         cf1: 14'h0000, cf2: 14'h0000};

    typedef enum logic {NFB_IDLE, NFB_RUN} nfb_run_t;
endpackage : nfb_pkg

// [rtl/nfb_fifo.sv]
/*
 Sample FIFO with valid/ready on both sides.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module nfb_fifo #(
    parameter int W = 16,
    parameter int D = 16
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [W-1:0] inData,
    input wire logic inVld,
    output logic inRdy,
    output logic [W-1:0] outData,
    output logic outVld,
    input wire logic outRdy
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } nfb_fifo_t;
    nfb_fifo_t s;
    nfb_fifo_t next_s;

    // Full when the pointers differ only in the wrap bit
    assign inRdy = (s.wp ^ s.rp) != {1'b1, {AW{1'b0}}};
    assign outVld = s.wp != s.rp;
    assign outData = s.mem[s.rp[AW-1:0]];

    always_comb begin
        next_s = s;
        if (inVld && inRdy) begin
            next_s.mem[s.wp[AW-1:0]] = inData;
            next_s.wp = s.wp + 1'b1;
        end
        if (outVld && outRdy) begin
            next_s.rp = s.rp + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : nfb_fifo

// [verif/nfb_stream_model.sv]
/*
 Stream partner of the notch filter bank: sample source and sink.
 Assumes the bench fills txQ, reads rxQ and sets stall.
*/
`timescale 1ns/1ns
module nfb_stream_model
    import nfb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    output logic [NFB_SMP_W-1:0] inSample,
    output logic inVld,
    input wire logic inRdy,
    input wire logic [NFB_SMP_W-1:0] outSample,
    input wire logic outVld,
    output logic outRdy
);
    logic [NFB_SMP_W-1:0] txQ[$];
    logic [NFB_SMP_W-1:0] rxQ[$];
    logic stall = 1'b0;
    initial begin
        inSample = 16'h5a5a;
        inVld = 1'b0;
        outRdy = 1'b0;
    end
    always @(posedge clk_sys) begin
        if (inVld && inRdy) begin
            void'(txQ.pop_front());
        end
        if (outVld && outRdy) begin
            rxQ.push_back(outSample);
        end
        inVld <= !srst && txQ.size() != 0;
        // Idle data toggles so a stale sample is never mistaken for fresh
        inSample <= (txQ.size() != 0) ? txQ[0] : ~inSample;
        outRdy <= !srst && !stall;
    end
endmodule : nfb_stream_model

// [verif/nfb_bank_test.sv]
/*
 Bench of the notch filter bank: registers, ranges, bypass, FIFO,
 notch attenuation and adaptive override. Assumes nfb_stream_model.
*/
`timescale 1ns/1ns
module nfb_bank_test
    import nfb_pkg::*;
;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] regRdata;
    logic [NFB_SMP_W-1:0] inSample;
    logic [NFB_SMP_W-1:0] outSample;
    logic inVld, inRdy, outVld, outRdy;
    logic adaptEn = 1'b0;
    nfb_notch_t adapt3 = '{freq: 13'h012c, width: 5'h04, depth: 7'h0a};
    nfb_notch_t adapt4 = '{freq: 13'h0190, width: 5'h06, depth: 7'h14};
    logic [15:0] rv;
    int error_cnt = 0;
    int compares = 0;
    logic [7:0] tA [15] = '{8'h01, 8'h01, 8'h01, 8'h18, 8'h02, 8'h02, 8'h03, 8'h03,
                            8'h2b, 8'h2c, 8'h27, 8'h27, 8'h28, 8'h29, 8'h2a};
    logic [15:0] tG [15] = '{16'h0064, 16'h0064, 16'h0064, 16'h0064, 16'h0002, 16'h0002,
                             16'h0000, 16'h0000, 16'h0002, 16'h0000, 16'h0032, 16'h0032,
                             16'h0005, 16'h0005, 16'h0064};
    logic [15:0] tV [15] = '{16'h000a, 16'h0009, 16'h1389, 16'h1388, 16'h0014, 16'h0015,
                             16'h0063, 16'h0064, 16'h0015, 16'h0063, 16'h03e8, 16'h03e9,
                             16'h2710, 16'h2711, 16'h000a};
    logic tOk [15] = '{1, 0, 0, 1, 1, 0, 1, 0, 0, 1, 1, 0, 1, 0, 1};

    always #4 clk_sys = ~clk_sys;

    nfb_bank DUT (.clk_sys(clk_sys), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .inSample(inSample),
        .inVld(inVld), .inRdy(inRdy), .outSample(outSample), .outVld(outVld),
        .outRdy(outRdy), .adaptEn(adaptEn), .adapt3(adapt3), .adapt4(adapt4));
    nfb_stream_model model (.clk_sys(clk_sys), .srst(srst), .inSample(inSample),
        .inVld(inVld), .inRdy(inRdy), .outSample(outSample), .outVld(outVld),
        .outRdy(outRdy));

    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // A one-cycle gap before each strobe keeps every driver edge single
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1;
        rv = regRdata;
    endtask : rd

    task automatic wait_rx(input int n);
        for (int i = 0; i < 20000 && model.rxQ.size() < n; i++) begin
            @(posedge clk_sys);
        end
        if (model.rxQ.size() < n) begin
            error_cnt++;
            $display("[ERR] %0t output samples missing", $time);
            tally_and_finish();
        end
    endtask : wait_rx

    function automatic int peak(input int from);
        int p = 0;
        for (int i = from; i < model.rxQ.size(); i++) begin
            int v = int'($signed(model.rxQ[i]));
            v = (v < 0) ? -v : v;
            p = (v > p) ? v : p;
        end
        return p;
    endfunction : peak

    task automatic sine(input int f);
        model.rxQ.delete();
        for (int i = 0; i < 400; i++) begin
            model.txQ.push_back(16'(int'(8000.0 * $sin(6.283185307 * f * i / NFB_SAMPLE_HZ))));
        end
        wait_rx(400);
    endtask : sine

    task automatic t_reset();
        for (int k = 0; k < 6; k++) begin
            rd(NFB_NOTCH_BASE[k]);
            chk(rv, 16'h1388, "reset freq");
            rd(NFB_NOTCH_BASE[k] + 8'h01);
            chk(rv, 16'h0002, "reset width");
            rd(NFB_NOTCH_BASE[k] + 8'h02);
            chk(rv, 16'h0000, "reset depth");
        end
        rd(8'hff);
        chk(rv, 16'h0000, "unmapped read");
        rd(NFB_ADDR_STAT);
        chk(rv, 16'h0000, "reset status");
    endtask : t_reset

    task automatic t_range();
        for (int k = 0; k < 15; k++) begin
            wr(tA[k], tG[k]);
            wr(tA[k], tV[k]);
            rd(tA[k]);
            chk(rv, tOk[k] ? tV[k] : tG[k], "range write");
        end
        wr(8'h01, 16'h1388);
        wr(8'h2a, 16'h1388);
        wr(NFB_ADDR_COEF, 16'h0000);
        wr(NFB_ADDR_CF1, 16'h0000);
        wr(NFB_ADDR_CF2, 16'h0000);
    endtask : t_range

    task automatic t_bypass();
        logic [15:0] s [5] = '{16'h7fff, 16'h8000, 16'h0001, 16'h1234, 16'hfedc};
        model.rxQ.delete();
        foreach (s[k]) model.txQ.push_back(s[k]);
        wait_rx(5);
        foreach (s[k]) chk(model.rxQ[k], s[k], "bypass sample");
    endtask : t_bypass

    task automatic t_fifo();
        model.rxQ.delete();
        model.stall = 1'b1;
        for (int k = 0; k < 20; k++) model.txQ.push_back(16'(3 * k + 1));
        for (int i = 0; i < 500 && inRdy !== 1'b0; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk({15'h0000, inRdy}, 16'h0000, "fifo full");
        // One sample in the engine plus sixteen queued
        chk(16'(model.txQ.size()), 16'h0003, "fifo accepted count");
        chk({15'h0000, outVld}, 16'h0001, "output held");
        model.stall = 1'b0;
        wait_rx(20);
        for (int k = 0; k < 20; k++) chk(model.rxQ[k], 16'(3 * k + 1), "fifo order");
    endtask : t_fifo

    task automatic t_notch();
        for (int k = 0; k < 6; k++) begin
            wr(NFB_NOTCH_BASE[k], 16'(500 * (k + 1)));
            wr(NFB_NOTCH_BASE[k] + 8'h01, (k == 0) ? 16'h0000 : 16'h0002);
            wr(NFB_NOTCH_BASE[k] + 8'h02, 16'h0000);
        end
        sine(1000);
        // Stage enables follow the snapshot, so read them once samples have run
        rd(NFB_ADDR_STAT);
        chk({8'h00, rv[7:0]}, 16'h003f, "stages enabled");
        chk(16'(peak(320) < 2000), 16'h0001, "centre not cut");
        wr(8'h06, 16'h0063);
        sine(1000);
        chk(16'(peak(320) > 5000), 16'h0001, "depth 99 not passing");
        for (int k = 0; k < 6; k++) wr(NFB_NOTCH_BASE[k], 16'h1388);
    endtask : t_notch

    task automatic t_adapt();
        @(posedge clk_sys);
        adaptEn <= 1'b1;
        wr(8'h07, 16'h0064);
        rd(8'h07);
        chk(rv, 16'h012c, "adaptive freq 3");
        rd(8'h08);
        chk(rv, 16'h0004, "adaptive width 3");
        rd(8'h0c);
        chk(rv, 16'h0014, "adaptive depth 4");
        rd(NFB_ADDR_STAT);
        chk({15'h0000, rv[8]}, 16'h0001, "adaptive status");
        @(posedge clk_sys);
        adaptEn <= 1'b0;
        wr(8'h07, 16'h1388);
        wr(8'h0a, 16'h1388);
        rd(8'h07);
        chk(rv, 16'h1388, "manual freq 3");
    endtask : t_adapt

    initial begin
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        t_reset();
        t_range();
        t_bypass();
        t_fifo();
        t_notch();
        t_adapt();
        tally_and_finish();
    end
endmodule : nfb_bank_test
